// file: sim/rpm_bus_partner.sv
// partner model: external bus master asking for the bus
module rpm_bus_partner (
  input wire logic clock,
  input wire logic wantBus,
  output logic     holdRequestN
);
  timeunit 1ns;
  timeprecision 1ps;
  initial holdRequestN = 1'b1;
  // level request, moved just after an edge and held while wanted
  always @(posedge clock) holdRequestN <= #1 !wantBus;
endmodule

// file: sim/rpm_reset_mode_ctrl_asserts.sv
// checker for reset, pin state and processor mode control
module rpm_reset_mode_ctrl_asserts (
  input wire logic       clock, resetn, modeSelectPin, holdRequestN, wdtUnderflow, modeWrite, softResetN,
  input wire logic       vectorFetch, wdtResetSelect, busPinsActive, chipSelectZeroN, writeStrobeN,
  input wire logic       readStrobeN, addressLatchEnable, holdAcknowledgeN,
  input wire logic [1:0] modeWriteData, processorModeField,
  input wire logic [2:0] otherChipSelectPullup
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // watchdog reset: low three cycles, vector fetch as it lifts
  property p_wd; wdtUnderflow && wdtResetSelect && softResetN |=> !softResetN [*3] ##1 (softResetN && vectorFetch);
  endproperty
  a_wd: assert property (p_wd) else $error("watchdog reset timing");
  property p_keep; wdtUnderflow && wdtResetSelect |=> ($stable(processorModeField) && wdtResetSelect) [*4]; endproperty
  a_keep: assert property (p_keep) else $error("mode lost");
  // pin flops have no reset, so a few edges pass before they are judged
  property p_pins; disable iff (1'b0) (!resetn && modeSelectPin) [*4] |-> chipSelectZeroN && writeStrobeN
    && readStrobeN && !addressLatchEnable && otherChipSelectPullup == 3'h7; endproperty
  a_pins: assert property (p_pins) else $error("reset pin state");
  property p_hold; disable iff (1'b0) (!resetn && modeSelectPin && !holdRequestN) [*5] |-> !holdAcknowledgeN;
  endproperty
  a_hold: assert property (p_hold) else $error("hold ack");
  // the forbidden code leaves the old mode
  property p_write; modeWrite && softResetN |=> processorModeField ==
    ($past(modeWriteData) == 2'h2 ? $past(processorModeField) : $past(modeWriteData)); endproperty
  a_write: assert property (p_write) else $error("mode write");
  property p_sel; wdtResetSelect |=> wdtResetSelect; endproperty
  a_sel: assert property (p_sel) else $error("select cleared");
  property p_strap; $rose(resetn) |-> ##4 processorModeField == {2{modeSelectPin}}; endproperty
  a_strap: assert property (p_strap) else $error("strap mode");
  property p_bus; softResetN && $past(softResetN) |-> busPinsActive == ($past(processorModeField) != 2'h0);
  endproperty
  a_bus: assert property (p_bus) else $error("bus pins");
  cover property (vectorFetch);
  cover property (busPinsActive);
  cover property (disable iff (1'b0) !holdAcknowledgeN);
endmodule
bind rpm_reset_mode_ctrl rpm_reset_mode_ctrl_asserts u_chk (.clock, .resetn, .modeSelectPin, .holdRequestN,
  .wdtUnderflow, .modeWrite, .softResetN, .vectorFetch, .wdtResetSelect, .busPinsActive, .chipSelectZeroN,
  .writeStrobeN, .readStrobeN, .addressLatchEnable, .holdAcknowledgeN, .modeWriteData, .processorModeField,
  .otherChipSelectPullup);

// file: sim/tb_reset_pin_state_mode_control.sv
// testbench for reset, pin state and processor mode control
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin errTotal++; \
  $display("ERROR %s exp %h got %h", n, e, a); end end
module tb_reset_pin_state_mode_control
  import rpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, resetn = 1'b0, modeSelectPin = 1'b1, wantBus = 1'b0, wdtUnderflow = 1'b0;
  logic modeWrite = 1'b0, wdtSelectWrite = 1'b0, wdtSelectWriteData = 1'b0, holdRequestN, softResetN;
  logic vectorFetch, wdtResetSelect, internalRomBlocked, busPinsActive, chipSelectZeroN, chipSelectZeroOe;
  logic writeStrobeN, readStrobeN, addressLatchEnable, holdAcknowledgeN;
  logic busStrobeOe, addressOe, holdAcknowledgeOe;
  logic [2:0] otherChipSelectOe;
  logic [19:0] addressOut;
  logic [1:0] modeWriteData = 2'h0, processorModeField;
  logic [2:0] otherChipSelectPullup;
  logic [5:0] accessSpace;
  logic [7:0] portOutputEnable;
  logic [19:0] vectorAddress;
  int checked = 0, errTotal = 0, cycles = 0;
  rpm_bus_partner PEER (.clock, .wantBus, .holdRequestN);
  rpm_reset_mode_ctrl #(.PORT_PINS(8)) DUT (.clock, .resetn, .modeSelectPin, .holdRequestN, .wdtUnderflow,
    .modeWrite, .modeWriteData, .wdtSelectWrite, .wdtSelectWriteData, .cpuAddress(20'h12345), .softResetN,
    .vectorFetch, .vectorAddress, .processorModeField, .wdtResetSelect, .internalRomBlocked, .accessSpace,
    .busPinsActive, .portOutputEnable, .chipSelectZeroN, .chipSelectZeroOe, .writeStrobeN, .readStrobeN,
    .busStrobeOe, .addressLatchEnable, .addressOe, .addressOut, .holdAcknowledgeN, .holdAcknowledgeOe,
    .otherChipSelectOe, .otherChipSelectPullup);
  // 40 MHz clock
  always #12.5 clock = ~clock;
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task automatic strobe(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic complete_run;
    if (errTotal == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // hardware reset with the strap at a level; far side asks for the bus when strapped high
  task automatic t_hw(input logic strap);
    resetn = 1'b0;
    modeSelectPin = strap;
    wantBus = strap;
    tick(12);
    if (!strap) `CHK("port oe", 9'h000, {chipSelectZeroOe, portOutputEnable})
    if (strap) `CHK("strobes", 4'he, {chipSelectZeroN, writeStrobeN, readStrobeN, addressLatchEnable})
    if (strap) `CHK("bus oe", 4'hf, {chipSelectZeroOe, busStrobeOe, addressOe, holdAcknowledgeOe})
    if (strap) `CHK("hold ack", 1'b0, holdAcknowledgeN)
    if (strap) `CHK("other cs", 6'h07, {otherChipSelectOe, otherChipSelectPullup})
    wantBus = 1'b0;
    resetn = 1'b1;
    tick(6);
    `CHK("address", 20'h12345, addressOut)
    `CHK("hold free", 1'b1, holdAcknowledgeN)
    `CHK("mode", {strap, strap}, processorModeField)
    `CHK("rom blocked", strap, internalRomBlocked)
    `CHK("select", 1'b0, wdtResetSelect)
  endtask
  // every mode code in turn; the forbidden one keeps the mode
  task automatic t_modes;
    logic [1:0] codes[4] = '{2'h1, 2'h3, 2'h2, 2'h0};
    logic [1:0] exp = 2'h0;
    foreach (codes[i]) begin
      modeWriteData = codes[i];
      strobe(modeWrite);
      if (codes[i] != 2'h2) exp = codes[i];
      tick(2);
      `CHK("mode", exp, processorModeField)
      if (exp == 2'h1) `CHK("space", 6'h3f, accessSpace)
      if (exp == 2'h3) `CHK("space", 6'h3b, accessSpace)
    end
  endtask
  // underflow ignored until select is set, then a reset sparing the mode
  task automatic t_wd;
    modeWriteData = 2'h1;
    strobe(modeWrite);
    strobe(wdtSelectWrite);
    strobe(wdtUnderflow);
    tick(3);
    `CHK("no reset", 2'h2, {softResetN, wdtResetSelect})
    wdtSelectWriteData = 1'b1;
    strobe(wdtSelectWrite);
    strobe(wdtUnderflow);
    `CHK("in reset", 1'b0, softResetN)
    tick(3);
    `CHK("vector", {1'b1, RPM_RESET_VECTOR}, {vectorFetch, vectorAddress})
    `CHK("kept", 3'h3, {processorModeField, wdtResetSelect})
  endtask
  initial begin
    t_hw(1'b1);
    t_hw(1'b0);
    t_modes;
    t_wd;
    t_hw(1'b0);
    complete_run;
  end
  // run needs about 80 cycles; a hang is cut at 1000
  always @(posedge clock) begin
    cycles++;
    if (cycles == 1000) begin
      errTotal++;
      complete_run;
    end
  end
endmodule

// file: src/rpm_pkg.sv
// package for reset, pin state and processor mode control
package rpm_pkg;
  // processor mode field encodings
  typedef enum logic [1:0] {
    RPM_MODE_SINGLE = 2'h0,
    RPM_MODE_EXPAND = 2'h1,
    RPM_MODE_BAD    = 2'h2,
    RPM_MODE_MICRO  = 2'h3
  } rpm_mode_e;

  // reset sequencer states, gray coded along idle -> assert -> release
  typedef enum logic [1:0] {
    RPM_ST_RUN     = 2'h0,
    RPM_ST_HOLD    = 2'h1,
    RPM_ST_RELEASE = 2'h3
  } rpm_state_e;

  // access space selector bits
  localparam int RPM_SP_SFR    = 0;
  localparam int RPM_SP_IRAM   = 1;
  localparam int RPM_SP_IROM   = 2;
  localparam int RPM_SP_EXT    = 3;
  localparam int RPM_SP_DRAM   = 4;
  localparam int RPM_SP_DROM   = 5;
  localparam int RPM_SP_WIDTH  = 6;

  // reset values
  localparam logic [1:0] RPM_MODE_RST  = 2'h0;
  localparam logic       RPM_WDSEL_RST = 1'b0;
  // watchdog hold count loaded on entry; the internal reset pulse lasts one cycle longer (three cycles)
  localparam logic [1:0] RPM_WDRST_CYCLES = 2'h2;
  // reset vector fetch request
  localparam logic [19:0] RPM_RESET_VECTOR = 20'hffffc;
endpackage

// file: src/rpm_reset_mode_ctrl.sv
// reset sources, pin state forcing while reset is low, and processor mode control
// Operation
// - watchdog underflow with select bit set resets pins, cpu, registers, then vector fetch; here the pins are not reset
// - watchdog reset keeps processor mode field and preserved registers
// - reset low with mode select low: all port pins are inputs
// - reset low, mode select high: chip select zero, write, read driven high
// - reset low, mode select high: address latch enable low, address undefined
// - reset low, mode select high: hold acknowledge follows hold request
// - reset low, mode select high: other chip selects inputs with pull-up
// - exactly three processor modes: single-chip, memory expansion, microprocessor
// - single-chip mode: pins are ports or peripheral pins only
// - memory expansion reaches registers, ram, rom, external, display ram and rom; here internal rom only if the strap was low at reset
// - microprocessor mode reaches all those except internal rom
// - expansion and microprocessor modes repurpose pins as bus control
// - mode field: 00 single, 01 expansion, 11 microprocessor; 10 never taken
// - watchdog reset select is set by writing 1; writing 0 does nothing
// - hardware reset enters single-chip if mode select low, else microprocessor

// structure
// - two-flop synchronisers for the strap and the hold request; the reset pin
//   acts asynchronously and is re-timed for the release edge only
// - a three-state sequencer stretches a watchdog request into a fixed internal
//   reset pulse; hardware reset always wins over it
// - the mode field is loaded from the strap once per hardware reset and is then
//   written by software only; the watchdog path never reaches it
// - access space and bus pin roles are decoded from the field one edge later
// - pin-state flops carry no reset so the reset-time pin table can be clocked out
//   while resetn is low
// limitations
// - the clock must run during reset, or the pin table is not applied
// - address pins show zero during reset; any value is allowed there
// - a mode write arriving before the strap capture is lost, as writes are refused
//   until the field has been loaded
module rpm_reset_mode_ctrl
  import rpm_pkg::*;
#(
  parameter int PORT_PINS = 8
) (
  input  wire logic                    clock,
  input  wire logic                    resetn,
  input  wire logic                    modeSelectPin,
  input  wire logic                    holdRequestN,
  input  wire logic                    wdtUnderflow,
  input  wire logic                    modeWrite,
  input  wire logic [1:0]              modeWriteData,
  input  wire logic                    wdtSelectWrite,
  input  wire logic                    wdtSelectWriteData,
  input  wire logic [19:0]             cpuAddress,
  output logic                         softResetN,
  output logic                         vectorFetch,
  output logic [19:0]                  vectorAddress,
  output logic [1:0]                   processorModeField,
  output logic                         wdtResetSelect,
  output logic                         internalRomBlocked,
  output logic [RPM_SP_WIDTH-1:0]      accessSpace,
  output logic                         busPinsActive,
  output logic [PORT_PINS-1:0]         portOutputEnable,
  output logic                         chipSelectZeroN,
  output logic                         chipSelectZeroOe,
  output logic                         writeStrobeN,
  output logic                         readStrobeN,
  output logic                         busStrobeOe,
  output logic                         addressLatchEnable,
  output logic                         addressOe,
  output logic [19:0]                  addressOut,
  output logic                         holdAcknowledgeN,
  output logic                         holdAcknowledgeOe,
  output logic [2:0]                   otherChipSelectOe,
  output logic [2:0]                   otherChipSelectPullup
);

  // pin synchronisers; first stage feeds only the second
  logic modeSelMeta, modeSelSync;
  logic holdMeta, holdSync;
  // reset pin sampled as a level in the clock domain for pin forcing
  logic rstMeta, rstSync, rstLate;

  // mode strap synchroniser, cleared by reset so the strap is only read once the
  // second stage has refilled after release
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      modeSelMeta <= 1'b0;
      modeSelSync <= 1'b0;
    end else begin
      modeSelMeta <= modeSelectPin;
      modeSelSync <= modeSelMeta;
    end
  end

  // hold request synchroniser without reset: the acknowledge must track the
  // request while resetn is low, so these stages may not be held by it
  always_ff @(posedge clock) begin
    holdMeta <= holdRequestN;
    holdSync <= holdMeta;
  end

  // reset release seen two edges later so mode strap is caught after release;
  // a third stage marks the first cycle after release without reading the first
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
      rstLate <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
      rstLate <= rstSync;
    end
  end

  // strap level live during reset: the pin table applies only while resetn is low,
  // and the clock is the only path, so this pair has no reset and keeps running
  logic strapMeta, strapSync;
  always_ff @(posedge clock) begin
    strapMeta <= modeSelectPin;
    strapSync <= strapMeta;
  end

  // watchdog reset sequencer; a request is honoured only in RUN, so an underflow
  // during HOLD or RELEASE is absorbed and the pulse length stays fixed
  rpm_state_e stateReg;
  logic [1:0] holdCountReg;
  logic       wdtResetReq;

  assign wdtResetReq = wdtUnderflow & wdtResetSelect;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      stateReg     <= RPM_ST_RUN;
      holdCountReg <= 2'h0;
    end else begin
      case (stateReg)
        RPM_ST_RUN: begin
          if (wdtResetReq && rstSync) begin
            stateReg     <= RPM_ST_HOLD;
            holdCountReg <= RPM_WDRST_CYCLES;
          end
        end
        RPM_ST_HOLD: begin
          // count guarantees every register sees the reset for full cycles
          if (holdCountReg <= 2'h1) begin
            stateReg <= RPM_ST_RELEASE;
          end else begin
            holdCountReg <= holdCountReg - 2'h1;
          end
        end
        RPM_ST_RELEASE: stateReg <= RPM_ST_RUN;
        default:        stateReg <= RPM_ST_RUN;
      endcase
    end
  end

  // soft reset to cpu and non-preserved registers, and vector fetch request
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      softResetN    <= 1'b0;
      vectorFetch   <= 1'b0;
      vectorAddress <= RPM_RESET_VECTOR;
    end else begin
      softResetN    <= rstSync && (stateReg != RPM_ST_HOLD) &&
                       !(stateReg == RPM_ST_RUN && wdtResetReq);
      // first cycle out of hardware or watchdog reset starts vector fetch,
      // in step with the rise of the internal reset in both cases
      vectorFetch   <= (rstSync && !rstLate) || (stateReg == RPM_ST_RELEASE);
      vectorAddress <= RPM_RESET_VECTOR;
    end
  end

  // watchdog reset select: only a 1 write sets it; only hardware reset clears it
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wdtResetSelect <= RPM_WDSEL_RST;
    end else if (wdtSelectWrite && wdtSelectWriteData) begin
      wdtResetSelect <= 1'b1;
    end
  end

  // processor mode field; watchdog reset does not touch it
  logic strapTaken;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      processorModeField <= RPM_MODE_RST;
      strapTaken         <= 1'b0;
      internalRomBlocked <= 1'b0;
    end else if (!strapTaken) begin
      // strap captured once after release, never by the watchdog path
      if (rstSync) begin
        strapTaken         <= 1'b1;
        processorModeField <= modeSelSync ? RPM_MODE_MICRO : RPM_MODE_SINGLE;
        internalRomBlocked <= modeSelSync;
      end
    end else if (modeWrite && softResetN && modeWriteData != RPM_MODE_BAD) begin
      // reserved code is dropped so the field only ever holds three modes
      processorModeField <= modeWriteData;
    end
  end

  // access space decode by mode; registered so every space bit is a clean flop,
  // at the price of one edge behind the mode field
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      accessSpace   <= '0;
      busPinsActive <= 1'b0;
    end else begin
      accessSpace <= '0;
      accessSpace[RPM_SP_SFR]  <= 1'b1;
      accessSpace[RPM_SP_IRAM] <= 1'b1;
      case (processorModeField)
        RPM_MODE_EXPAND: begin
          accessSpace[RPM_SP_IROM] <= !internalRomBlocked;
          accessSpace[RPM_SP_EXT]  <= 1'b1;
          accessSpace[RPM_SP_DRAM] <= 1'b1;
          accessSpace[RPM_SP_DROM] <= 1'b1;
        end
        RPM_MODE_MICRO: begin
          accessSpace[RPM_SP_EXT]  <= 1'b1;
          accessSpace[RPM_SP_DRAM] <= 1'b1;
          accessSpace[RPM_SP_DROM] <= 1'b1;
        end
        default: accessSpace[RPM_SP_IROM] <= !internalRomBlocked;
      endcase
      busPinsActive <= (processorModeField == RPM_MODE_EXPAND) ||
                       (processorModeField == RPM_MODE_MICRO);
    end
  end

  // pin state: forced table while reset low, mode-driven afterwards.
  // these flops have no async reset so the table can be applied while resetn is low.
  // the strap decides during reset and the decoded mode after it, so in a bus mode
  // the bus pins float for two cycles between the two
  logic busMode;
  assign busMode = rstSync ? busPinsActive : strapSync;

  // general port pins stay inputs; the port logic proper lives outside this block
  for (genvar pinIdx = 0; pinIdx < PORT_PINS; pinIdx++) begin : g_port
    always_ff @(posedge clock) begin
      portOutputEnable[pinIdx] <= 1'b0;
    end
  end

  // bus strobes stay inactive high; this block starts no bus cycle itself
  always_ff @(posedge clock) begin
    chipSelectZeroN <= 1'b1;
    writeStrobeN    <= 1'b1;
    readStrobeN     <= 1'b1;
  end

  // strobe drivers enabled only in the bus modes so single-chip pins stay inputs
  always_ff @(posedge clock) begin
    chipSelectZeroOe <= busMode;
    busStrobeOe      <= busMode;
  end

  // address latch held low; address shows zero during reset, any value allowed
  always_ff @(posedge clock) begin
    addressLatchEnable <= 1'b0;
    addressOe          <= busMode;
    if (rstSync) begin
      addressOut <= cpuAddress;
    end else begin
      addressOut <= 20'h00000;
    end
  end

  // hold acknowledge follows the synchronised request in the bus modes, reset
  // or not; two edges of latency are the price of a clean pin sample
  always_ff @(posedge clock) begin
    holdAcknowledgeOe <= busMode;
    if (busMode) begin
      holdAcknowledgeN <= holdSync;
    end else begin
      holdAcknowledgeN <= 1'b1;
    end
  end

  // other chip selects: inputs, pulled up only during reset with the strap high
  always_ff @(posedge clock) begin
    otherChipSelectOe     <= 3'h0;
    otherChipSelectPullup <= (busMode && !rstSync) ? 3'h7 : 3'h0;
  end

endmodule
